/* File: dv/dioc_field.sv */
// Purpose: pin-side wiring of the card, one external source per line
// Assumes: no contention, the card wins wherever it drives
// Notes:   driven lines loop back, so input reads see the latched value
`timescale 1ns/1ps
module dioc_field (
	input  wire logic [95:0] line_out,
	input  wire logic [95:0] line_oe,
	input  wire logic [95:0] ext_drive,
	output logic      [95:0] line_in
);
	import dioc_pkg::*;
	assign line_in = (line_out & line_oe) | (ext_drive & ~line_oe);
endmodule : dioc_field

/* File: dv/tb_top.sv */
// Purpose: self-checking bench of the digital I/O card
// Assumes: base 2d0 at first, switches as levels
// Notes:   register access through Avalon-MM read and write calls
`timescale 1ns/1ps
module tb_top;
	import dioc_pkg::*;
	localparam logic [9:0] BASE = 10'h2d0;
	logic core_clk, rstn, avs_read, avs_write, aen, avs_waitrequest;
	logic [9:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata;
	logic [5:0] addr_sw_on, irq_route_jumper, irq_line, irq_oe;
	dioc_lines_t [3:0] line_in, line_out, line_oe;
	logic [95:0] ext;
	logic [7:0] q;
	int fail_count, compares, cyc;

	dioc_card #(.UNITS(4)) uut (.core_clk(core_clk), .rstn(rstn), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .aen(aen),
		.addr_sw_on(addr_sw_on), .irq_route_jumper(irq_route_jumper), .line_in(line_in),
		.line_out(line_out), .line_oe(line_oe), .irq_line(irq_line), .irq_oe(irq_oe));
	dioc_field field (.line_out(line_out), .line_oe(line_oe), .ext_drive(ext), .line_in(line_in));

	always #25 core_clk = ~core_clk;

	task summarize;
		$display("compares=%0d fail_count=%0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : summarize

	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 5000) begin
			fail_count++;
			summarize();
		end
	end

	task chk(input logic [95:0] got, input logic [95:0] exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	function automatic logic [9:0] adr(input int u, input int r);
		return BASE + 10'(4 * u + r);
	endfunction : adr

	// called in a rising-edge time step; waitrequest and readdata are read at each
	// rising edge before its updates land; one idle cycle after so results settle
	task acc(input logic w, input logic [9:0] a, input logic [7:0] d);
		avs_address <= a;
		avs_writedata <= {24'h0, d};
		avs_write <= w;
		avs_read <= !w;
		do begin
			@(posedge core_clk);
		end while (avs_waitrequest !== 1'b0);
		q = avs_readdata[7:0];
		if (!w)
			chk(avs_readdata[31:8], 24'h0);
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge core_clk);
	endtask : acc

	task do_reset;
		rstn <= 1'b0;
		repeat (2) @(posedge core_clk);
		rstn <= 1'b1;
		repeat (3) @(posedge core_clk);
	endtask : do_reset

	logic [7:0] ctl [4] = '{8'h98, 8'h81, 8'h8a, 8'h91};
	logic [23:0] oe_exp [4] = '{24'h00ff0f, 24'hfffff0, 24'hff000f, 24'h00fff0};

	initial begin
		core_clk = 0; rstn = 0; avs_read = 0; avs_write = 0; aen = 0; avs_address = '0;
		avs_writedata = '0; addr_sw_on = 6'h12; irq_route_jumper = 6'h00;
		ext = 96'h3c5a69_a55a71_0f1e22_77e833;
		fail_count = 0; compares = 0; cyc = 0;
		do_reset();
		chk(line_oe, 96'h0);
		chk(irq_oe, 6'h0);
		for (int u = 0; u < 4; u++) begin
			acc(1'b0, adr(u, 0), 8'h00);
			chk(q, ext[u*24+16 +: 8]);
		end
		$display("test reset and live inputs done");
		for (int u = 0; u < 4; u++) begin
			acc(1'b1, adr(u, 3), 8'h80);
			acc(1'b1, adr(u, 0), 8'ha0 + 8'(u));
			acc(1'b1, adr(u, 1), 8'hb0 + 8'(u));
			acc(1'b1, adr(u, 2), 8'hc0 + 8'(u));
			chk(line_oe[u], 24'hffffff);
			chk(line_out[u], {8'ha0 + 8'(u), 8'hb0 + 8'(u), 8'hc0 + 8'(u)});
			acc(1'b0, adr(u, 1), 8'h00);
			chk(q, 8'hb0 + 8'(u));
			acc(1'b0, adr(u, 3), 8'h00);
			chk(q, CTRL_READ);
		end
		$display("test output latches done");
		for (int k = 0; k < 4; k++) begin
			acc(1'b1, adr(2, 3), ctl[k]);
			chk(line_oe[2], oe_exp[k]);
		end
		acc(1'b1, adr(2, 3), 8'h98);
		acc(1'b0, adr(2, 2), 8'h00);
		chk(q, {ext[48+4 +: 4], 4'h2});
		acc(1'b1, adr(2, 3), 8'h01);
		acc(1'b0, adr(2, 2), 8'h00);
		chk({line_oe[2], q}, {24'h00ff0f, ext[52 +: 4], 4'h3});
		$display("test direction split done");
		aen <= 1'b1;
		acc(1'b1, adr(0, 1), 8'h5a);
		aen <= 1'b0;
		for (int b = 4; b < 10; b++) begin
			acc(1'b1, adr(0, 1) ^ (10'h1 << b), 8'h5a);
			acc(1'b0, adr(0, 0) ^ (10'h1 << b), 8'h00);
			chk(q, 8'h00);
		end
		chk(line_out[0].b, 8'hb0);
		addr_sw_on <= 6'h3f;
		acc(1'b1, 10'h001, 8'h5a);
		chk(line_out[0].b, 8'h5a);
		$display("test address decode done");
		ext <= '0;
		do_reset();
		chk(line_oe, 96'h0);
		chk(line_out, 96'h0);
		for (int j = 0; j < 6; j++) begin
			irq_route_jumper <= 6'h1 << j;
			ext[(j%4)*24+3] <= 1'b1;
			repeat (3) @(posedge core_clk);
			chk({irq_oe, irq_line}, {6'h1 << j, 6'h1 << j});
			ext[(j%4)*24+7] <= 1'b1;
			repeat (3) @(posedge core_clk);
			chk(irq_line, 6'h0);
			ext[(j%4)*24+7] <= 1'b0;
			ext[(j%4)*24+3] <= 1'b0;
			repeat (3) @(posedge core_clk);
			chk(irq_line, 6'h0);
		end
		irq_route_jumper <= 6'h0;
		ext[3] <= 1'b1;
		repeat (3) @(posedge core_clk);
		chk(irq_oe, 6'h0);
		$display("test interrupt routing done");
		summarize();
	end
endmodule : tb_top

/* File: rtl/dioc_card.sv */
// Purpose: 96-line digital I/O card, four port units behind a 16-byte window
// Assumes: Avalon-MM word address equals the host I/O port number
// Notes:   one wait state on every access, mapped or not
// Overview of operation
// - The card answers exactly sixteen consecutive I/O addresses, based on any sixteen-address boundary in 000-3ff.
// - Address bits 9..4 must equal the switch settings, an on switch meaning 0 and an off switch 1.
// - Address bits 3..0 pick the register inside the port units.
// - Four port units give 96 lines, each with 8-bit ports a, b and c.
// - Each port is a group of inputs or latched outputs, and port c halves choose independently.
// - Port c bit 3 is the user interrupt input, active high.
// - The interrupt passes only while port c bit 7 is low.
// - The gated interrupts of all units are OR'ed into one request.
// - The jumper steers that request to one of IRQ2..IRQ7, and no jumper drives none.
// - Control is write-only at group offset 3, ports a, b, c read/write at offsets 0..2.
// - After reset every line is an input.
// - Control bits 0, 1, 3, 4 set direction (1 input), bits 2, 5, 6 mode, bit 7 mode set.
// - Outputs hold the last write; inputs read the live pins.
`timescale 1ns/1ps
module dioc_card
	import dioc_pkg::*;
#(
	parameter int unsigned UNITS = 4
) (
	input  wire logic                                  core_clk,
	input  wire logic                                  rstn,
	input  wire logic [dioc_pkg::IO_ADDR_W-1:0]        avs_address,
	input  wire logic                                  avs_read,
	input  wire logic                                  avs_write,
	input  wire logic [31:0]                           avs_writedata,
	output logic      [31:0]                           avs_readdata,
	output logic                                       avs_waitrequest,
	input  wire logic                                  aen,
	input  wire logic [dioc_pkg::BASE_W-1:0]           addr_sw_on,
	input  wire logic [dioc_pkg::IRQ_LINES-1:0]        irq_route_jumper,
	input  wire dioc_pkg::dioc_lines_t [UNITS-1:0]     line_in,
	output dioc_pkg::dioc_lines_t      [UNITS-1:0]     line_out,
	output dioc_pkg::dioc_lines_t      [UNITS-1:0]     line_oe,
	output logic      [dioc_pkg::IRQ_LINES-1:0]        irq_line,
	output logic      [dioc_pkg::IRQ_LINES-1:0]        irq_oe
);
	import dioc_pkg::*;

	// four byte groups fill the sixteen-byte window exactly
	if (UNITS != NUM_UNITS) begin : g_units_check
		$error("dioc_card serves exactly four port units");
	end

	// reset release through two flops; assertion stays asynchronous
	// every unit leaves reset on the same edge, so none sees a half-reset bus
	logic rst_meta;
	logic rst_n;

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// address decode
	logic       req;
	logic       hit;
	logic [1:0] unit_sel;
	logic [1:0] reg_sel;

	assign req      = avs_read | avs_write;
	// aen high marks a dma cycle whose address is not meant for the card
	assign hit      = !aen && (avs_address[IO_ADDR_W-1:BASE_LSB] == ~addr_sw_on);
	assign unit_sel = avs_address[BASE_LSB-1:UNIT_LSB];
	assign reg_sel  = avs_address[UNIT_LSB-1:0];

	// bus handshake: answer one cycle after the request is seen
	// ack lasts one cycle, so a request still held is not taken again on the next edge
	logic        ack;
	logic        next_ack;
	logic [31:0] next_readdata;
	logic [7:0]  unit_rd [UNITS];
	logic [UNITS-1:0] unit_irq;

	always_comb begin
		next_ack      = req && !ack;
		next_readdata = avs_readdata;
		if (avs_read && !ack) begin
			// unmapped reads answer zero rather than stalling the bus
			if (hit)
				next_readdata = {24'h000000, unit_rd[unit_sel]};
			else
				next_readdata = 32'h00000000;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ack          <= 1'b0;
			avs_readdata <= 32'h00000000;
		end else begin
			ack          <= next_ack;
			avs_readdata <= next_readdata;
		end
	end

	// combinational, so the single wait state costs no extra cycle
	assign avs_waitrequest = req && !ack;

	// port units
	for (genvar u = 0; u < UNITS; u++) begin : g_unit
		logic unit_wr;

		assign unit_wr = avs_write && ack && hit && (unit_sel == 2'(u));

		// read and write share one register index, as the bus carries one address
		dioc_port_unit u_port (
			.core_clk (core_clk),
			.rst_n    (rst_n),
			.wr_en    (unit_wr),
			.wr_reg   (reg_sel),
			.wr_data  (avs_writedata[7:0]),
			.rd_reg   (reg_sel),
			.rd_data  (unit_rd[u]),
			.line_in  (line_in[u]),
			.line_out (line_out[u]),
			.line_oe  (line_oe[u]),
			.irq_req  (unit_irq[u])
		);
	end

	// interrupt combining and steering; a second jumper is ignored,
	// so two host lines are never shorted together
	logic [IRQ_LINES-1:0] route;
	logic [IRQ_LINES-1:0] next_irq_oe;
	logic [IRQ_LINES-1:0] next_irq_line;
	logic                 irq_any;

	assign irq_any = |unit_irq;

	always_comb begin
		route = '0;
		// scanning downward lets the lowest fitted jumper overwrite the rest
		for (int i = IRQ_LINES - 1; i >= 0; i--) begin
			if (irq_route_jumper[i])
				route = IRQ_LINES'(1) << i;
		end
		next_irq_oe   = route;
		next_irq_line = route & {IRQ_LINES{irq_any}};
	end

	// registered so a jumper change cannot glitch the host line
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_oe   <= '0;
			irq_line <= '0;
		end else begin
			irq_oe   <= next_irq_oe;
			irq_line <= next_irq_line;
		end
	end

	sequence bus_req_s;
		req && !ack;
	endsequence

	sequence bus_done_s;
		!avs_waitrequest && ack;
	endsequence

	bus_answer_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		bus_req_s |=> bus_done_s)
		else $error("bus access not answered in one cycle");
	miss_read_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		avs_read && !ack && !hit ##1 avs_read && ack |-> avs_readdata == 32'h00000000)
		else $error("unmapped read returned data");
	miss_write_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		!hit |-> !(|{g_unit[0].unit_wr, g_unit[1].unit_wr, g_unit[2].unit_wr, g_unit[3].unit_wr}))
		else $error("write reached a unit outside the window");
	irq_or_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		rst_n |=> (irq_line != '0) == ($past(irq_any) && $past(irq_route_jumper) != '0))
		else $error("combined interrupt not driven");
	irq_one_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		$onehot0(irq_oe) && (irq_line & ~irq_oe) == '0)
		else $error("interrupt driven on several lines");
	no_jumper_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		irq_route_jumper == '0 |=> irq_oe == '0)
		else $error("interrupt line driven without jumper");

	// a write to port b of a hit unit, taken at the edge with ack high
	sequence port_b_write_s;
		avs_write && ack && hit && reg_sel == REG_PORT_B;
	endsequence

	first_wait_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		$rose(req) |-> avs_waitrequest)
		else $error("new request not held for a wait state");
	read_pad_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		avs_read && ack |-> avs_readdata[31:8] == 24'h000000)
		else $error("read data upper bytes not zero");
	write_land_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		port_b_write_s |=> line_out[$past(unit_sel)].b == $past(avs_writedata[7:0]))
		else $error("port b write did not reach its latch");
	// written as a bitwise mismatch so it does not merely restate the decode
	sw_match_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		hit == (!aen && (&(avs_address[IO_ADDR_W-1:BASE_LSB] ^ addr_sw_on))))
		else $error("window decode disagrees with switches");
	aen_block_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		aen && avs_write && ack |=> $stable(line_out))
		else $error("write decoded during address enable");
	route_low_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		rst_n |=> irq_oe == ($past(irq_route_jumper) & (~$past(irq_route_jumper) + IRQ_LINES'(1))))
		else $error("interrupt not steered to lowest jumper");
	irq_idle_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		rst_n && !irq_any |=> irq_line == '0)
		else $error("interrupt line high without request");
	// no disable here: this one watches the reset itself
	reset_quiet_a: assert property (@(posedge core_clk)
		!rst_n |-> irq_oe == '0 && irq_line == '0 && avs_readdata == 32'h00000000)
		else $error("outputs not quiet during reset");

endmodule : dioc_card

/* File: rtl/dioc_pkg.sv */
// Purpose: shared constants and carrier types of the 96-line digital I/O card
// Assumes: four parallel port units, four byte registers each
// Notes:   register indices are word indices on the Avalon-MM slave
package dioc_pkg;

	// host I/O address layout
	localparam int unsigned IO_ADDR_W  = 10;
	localparam int unsigned BASE_LSB   = 4;
	localparam int unsigned UNIT_LSB   = 2;
	localparam int unsigned BASE_W     = IO_ADDR_W - BASE_LSB;
	localparam int unsigned NUM_UNITS  = 4;
	localparam int unsigned IRQ_LINES  = 6;

	// register index inside one unit's four-byte group
	localparam logic [1:0] REG_PORT_A = 2'h0;
	localparam logic [1:0] REG_PORT_B = 2'h1;
	localparam logic [1:0] REG_PORT_C = 2'h2;
	localparam logic [1:0] REG_CTRL   = 2'h3;

	// control register fields
	localparam int unsigned CTRL_DIR_CLO = 0;
	localparam int unsigned CTRL_DIR_B   = 1;
	localparam int unsigned CTRL_MODE_B  = 2;
	localparam int unsigned CTRL_DIR_CHI = 3;
	localparam int unsigned CTRL_DIR_A   = 4;
	localparam int unsigned CTRL_MODE_LO = 5;
	localparam int unsigned CTRL_MODE_HI = 6;
	localparam int unsigned CTRL_SET     = 7;
	localparam logic [7:0]  CTRL_RESET   = 8'h9b;
	localparam logic [7:0]  LATCH_RESET  = 8'h00;
	localparam logic [7:0]  CTRL_READ    = 8'h00;

	// port c lines used for the user interrupt
	localparam int unsigned IRQ_IN_BIT   = 3;
	localparam int unsigned IRQ_GATE_BIT = 7;

	typedef struct packed {
		logic [7:0] a;
		logic [7:0] b;
		logic [7:0] c;
	} dioc_lines_t;

endpackage : dioc_pkg

/* File: rtl/dioc_port_unit.sv */
// Purpose: one parallel port unit, ports a, b and c plus write-only control
// Assumes: mode 0 only; register access strobes come from the card decoder
// Notes:   mode 1 and mode 2 codes are stored but behave as mode 0
`timescale 1ns/1ps
module dioc_port_unit
	import dioc_pkg::*;
(
	input  wire logic                 core_clk,
	input  wire logic                 rst_n,
	input  wire logic                 wr_en,
	input  wire logic [1:0]           wr_reg,
	input  wire logic [7:0]           wr_data,
	input  wire logic [1:0]           rd_reg,
	output logic      [7:0]           rd_data,
	input  wire dioc_pkg::dioc_lines_t line_in,
	output dioc_pkg::dioc_lines_t     line_out,
	output dioc_pkg::dioc_lines_t     line_oe,
	output logic                      irq_req
);
	import dioc_pkg::*;

	logic [7:0] ctrl;
	logic [7:0] next_ctrl;
	logic [7:0] pa;
	logic [7:0] next_pa;
	logic [7:0] pb;
	logic [7:0] next_pb;
	logic [7:0] pc;
	logic [7:0] next_pc;
	logic       next_irq_req;

	always_comb begin
		next_ctrl = ctrl;
		next_pa   = pa;
		next_pb   = pb;
		next_pc   = pc;
		if (wr_en) begin
			case (wr_reg)
				REG_PORT_A: next_pa = wr_data;
				REG_PORT_B: next_pb = wr_data;
				REG_PORT_C: next_pc = wr_data;
				default: begin
					// flag clear: single bit set/reset of the port c latch
					if (wr_data[CTRL_SET])
						next_ctrl = wr_data;
					else
						next_pc[wr_data[3:1]] = wr_data[0];
				end
			endcase
		end
		next_irq_req = line_in.c[IRQ_IN_BIT] & ~line_in.c[IRQ_GATE_BIT];
	end

	// every line comes up as an input, latches cleared
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl    <= CTRL_RESET;
			pa      <= LATCH_RESET;
			pb      <= LATCH_RESET;
			pc      <= LATCH_RESET;
			irq_req <= 1'b0;
		end else begin
			ctrl    <= next_ctrl;
			pa      <= next_pa;
			pb      <= next_pb;
			pc      <= next_pc;
			irq_req <= next_irq_req;
		end
	end

	assign line_out = '{a: pa, b: pb, c: pc};
	assign line_oe  = '{a: {8{~ctrl[CTRL_DIR_A]}}, b: {8{~ctrl[CTRL_DIR_B]}},
		c: {{4{~ctrl[CTRL_DIR_CHI]}}, {4{~ctrl[CTRL_DIR_CLO]}}}};

	// inputs read the live pins, outputs read back their latch
	always_comb begin
		rd_data = CTRL_READ;
		case (rd_reg)
			REG_PORT_A: rd_data = ctrl[CTRL_DIR_A] ? line_in.a : pa;
			REG_PORT_B: rd_data = ctrl[CTRL_DIR_B] ? line_in.b : pb;
			REG_PORT_C: rd_data = {ctrl[CTRL_DIR_CHI] ? line_in.c[7:4] : pc[7:4],
				ctrl[CTRL_DIR_CLO] ? line_in.c[3:0] : pc[3:0]};
			default:    rd_data = CTRL_READ;
		endcase
	end

	sequence mode_set_s;
		wr_en && wr_reg == REG_CTRL && wr_data[CTRL_SET];
	endsequence

	mode_set_load_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		mode_set_s |=> ctrl == $past(wr_data))
		else $error("mode set write not loaded into control");
	out_latch_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		wr_en && wr_reg == REG_PORT_A && !ctrl[CTRL_DIR_A] ##1 !wr_en [*2]
		|-> line_out.a == $past(wr_data, 2) && line_oe.a == 8'hff)
		else $error("port a output latch lost its value");
	input_live_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		rd_reg == REG_PORT_B && ctrl[CTRL_DIR_B] |-> rd_data == line_in.b && line_oe.b == 8'h00)
		else $error("port b input not live");
	ctrl_wo_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		rd_reg == REG_CTRL |-> rd_data == 8'h00)
		else $error("control register readable");
	nibble_dir_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		line_oe.c[3:0] == {4{~ctrl[CTRL_DIR_CLO]}} && line_oe.c[7:4] == {4{~ctrl[CTRL_DIR_CHI]}})
		else $error("port c nibble direction wrong");
	irq_gate_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		rst_n |=> irq_req == ($past(line_in.c[IRQ_IN_BIT]) && !$past(line_in.c[IRQ_GATE_BIT])))
		else $error("user interrupt gating wrong");
	reset_input_a: assert property (@(posedge core_clk)
		$rose(rst_n) |-> line_oe == '0)
		else $error("line driven after reset");

endmodule : dioc_port_unit
